// [tpwm_timer.sv]
// Timer slice: comparator counting, single and dual PWM, with APB registers
// ==========================================================
// Summary of operation
// - Comparator mode counts comparator edges
// - Polarity picks edge and initial output
// - Prescaler bypassed in comparator mode
// - Catch pulses of two clocks or more
// - Reload raises event, restarts at one
// - Output toggles at each comparator reload
// - Written start count governs first pass
// - Single PWM toggles output at match
// - PWM reload raises event, restarts at one
// - Polarity one: start high, match low
// - Polarity zero: start low, match high
// - Dual mode drives complement output
// - Deadband delays rising edges 0 to 128
// - Dual mode takes over input pin
// - PWM start count governs first period
// - Period equals reload times prescale
// - Count minus start equals edges
// - Prescaler divides by 1 to 128
// - Count wraps from all ones to zero
//
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/10ps
`include "tpwm_defines.svh"
module tpwm_timer
  import tpwm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Comparator and pins
  input wire logic comparator_out,
  output logic timer_out_q,
  output logic timer_out_comp_q,
  output logic timer_in_select,
  output logic reload_event_q
);
  logic [7:0] ctl0_q;
  logic [7:0] ctl1_q;
  logic [15:0] count_q;
  logic [15:0] reload_q;
  logic [15:0] match_q;
  logic [7:0] dead_q;
  logic [2:0] pre_exp;
  logic [6:0] pre_cnt_q;
  logic level_q;
  logic [1:0] sync_q;
  logic cmp_prev_q;
  logic enabled_prev_q;
  logic wr_en;
  logic rd_en;
  logic tick;
  logic edge_seen;
  logic at_reload;
  logic at_match;
  logic enabled;
  logic polarity;
  logic out_en;
  logic mode_cmp;
  logic mode_pwm1;
  logic mode_pwm2;
  logic db_p;
  logic db_n;

  // Mode decode, shared by several conditions
  function automatic logic mode_is(input logic [7:0] c0, input logic [7:0] c1,
                                   input tpwm_mode_type m);
    mode_is = ({c0[`TPWM_CTL0_EXTRA_BIT], c1[`TPWM_CTL1_MODE_LSB +: 3]} == m);
  endfunction : mode_is

  // ==========================================================
  // Control decode
  assign enabled = ctl1_q[`TPWM_CTL1_ENABLE_BIT];
  assign polarity = ctl1_q[`TPWM_CTL1_POL_BIT];
  assign out_en = ctl0_q[`TPWM_CTL0_OUTEN_BIT];
  assign mode_cmp = mode_is(ctl0_q, ctl1_q, TPWM_MODE_CMPCNT);
  assign mode_pwm1 = mode_is(ctl0_q, ctl1_q, TPWM_MODE_PWM1);
  assign mode_pwm2 = mode_is(ctl0_q, ctl1_q, TPWM_MODE_PWM2);
  assign timer_in_select = ~mode_pwm2;

  // ==========================================================
  // APB slave, zero wait states, unmapped reads zero with error
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & (paddr > `TPWM_OFF_DEAD || paddr[1:0] != 2'b00);

  // Read data registered in setup phase so it stands through access
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      prdata <= 32'h0000_0000;
    else if (rd_en && !penable)
    begin
      case (paddr)
        `TPWM_OFF_CTL0: prdata <= {24'h000000, ctl0_q};
        `TPWM_OFF_CTL1: prdata <= {24'h000000, ctl1_q};
        `TPWM_OFF_COUNT: prdata <= {16'h0000, count_q};
        `TPWM_OFF_RELOAD: prdata <= {16'h0000, reload_q};
        `TPWM_OFF_MATCH: prdata <= {16'h0000, match_q};
        `TPWM_OFF_DEAD: prdata <= {24'h000000, dead_q};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // software sets up while disabled
  // Configuration registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctl0_q <= 8'h00;
      ctl1_q <= 8'h00;
      reload_q <= `TPWM_RELOAD_RESET;
      match_q <= `TPWM_MATCH_RESET;
      dead_q <= `TPWM_DEAD_RESET;
    end
    else if (wr_en)
    begin
      case (paddr)
        `TPWM_OFF_CTL0: ctl0_q <= pwdata[7:0];
        `TPWM_OFF_CTL1: ctl1_q <= pwdata[7:0];
        `TPWM_OFF_RELOAD: reload_q <= pwdata[15:0];
        `TPWM_OFF_MATCH: match_q <= pwdata[15:0];
        `TPWM_OFF_DEAD: dead_q <= (pwdata[7:0] > `TPWM_DEAD_MAX) ? `TPWM_DEAD_MAX : pwdata[7:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Comparator synchroniser and edge detector
  // two flip-flop synchroniser
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sync_q <= 2'b00;
    else
      sync_q <= {sync_q[0], comparator_out};
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cmp_prev_q <= 1'b0;
    else
      cmp_prev_q <= sync_q[1];
  end

  assign edge_seen = polarity ? (sync_q[1] & ~cmp_prev_q) : (~sync_q[1] & cmp_prev_q);

  // ==========================================================
  // Prescaler, divide by 2 to the power of pre_exp
  assign pre_exp = ctl1_q[`TPWM_CTL1_PRE_LSB +: 3];
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pre_cnt_q <= 7'h00;
    else if (!enabled || mode_cmp)
      pre_cnt_q <= 7'h00;
    else if (tick)
      pre_cnt_q <= 7'h00;
    else
      pre_cnt_q <= pre_cnt_q + 7'h01;
  end

  always_comb
  begin
    if (!enabled)
      tick = 1'b0;
    else if (mode_cmp)
      tick = edge_seen;
    else if (mode_pwm1 || mode_pwm2)
      tick = (pre_cnt_q == 7'((8'h01 << pre_exp) - 8'h01));
    else
      tick = 1'b0;
  end

  assign at_reload = (count_q == reload_q);
  assign at_match = (count_q == match_q);

  // ==========================================================
  // Counter; software may write it, hardware reload wins
  // start count only first pass
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      count_q <= `TPWM_COUNT_RESET;
    else if (tick && at_reload)
      count_q <= `TPWM_RELOAD_START;
    else if (wr_en && paddr == `TPWM_OFF_COUNT)
      count_q <= pwdata[15:0];
    else if (tick)
      count_q <= count_q + 16'h0001;
  end

  // Reload event pulse, one cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      reload_event_q <= 1'b0;
    else
      reload_event_q <= tick & at_reload;
  end

  // ==========================================================
  // Output level
  // period set by reload and prescale
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      enabled_prev_q <= 1'b0;
    else
      enabled_prev_q <= enabled;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      level_q <= 1'b0;
    else if (!enabled)
      level_q <= polarity;
    else if (tick && at_reload && (mode_pwm1 || mode_pwm2))
      level_q <= polarity;
    else if (tick && at_reload && mode_cmp)
      level_q <= ~level_q;
    else if (tick && at_match && (mode_pwm1 || mode_pwm2))
      level_q <= ~level_q;
  end

  // ==========================================================
  // Dual output with deadband
  // complement on second pin
  tpwm_deadband u_deadband (
    .clk(clk),
    .rst_n(rst_n),
    .active(enabled & mode_pwm2),
    .dead_cycles(dead_q),
    .level(level_q),
    .out_p_q(db_p),
    .out_n_q(db_n)
  );

  // Pin drivers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      timer_out_q <= 1'b0;
      timer_out_comp_q <= 1'b0;
    end
    else if (mode_pwm2 && enabled)
    begin
      timer_out_q <= db_p;
      timer_out_comp_q <= db_n;
    end
    else
    begin
      timer_out_q <= out_en ? level_q : 1'b0;
      timer_out_comp_q <= 1'b0;
    end
  end

  // ==========================================================
  // Checks
  // reload restarts count at one
  reload_restart_a: assert property (@(posedge clk) disable iff (!rst_n)
    (tick && at_reload) |=> (count_q == 16'h0001 && reload_event_q))
    else $error("Reload did not restart count");
  cmp_toggle_a: assert property (@(posedge clk) disable iff (!rst_n)
    (enabled && mode_cmp && tick && at_reload) |=> (level_q != $past(level_q)))
    else $error("Comparator reload did not toggle");
  pwm_restore_a: assert property (@(posedge clk) disable iff (!rst_n)
    (enabled && mode_pwm1 && tick && at_reload) |=> (level_q == $past(polarity)))
    else $error("PWM level not restored at reload");
  match_toggle_a: assert property (@(posedge clk) disable iff (!rst_n)
    (enabled && mode_pwm1 && tick && at_match && !at_reload) |=> (level_q == !$past(level_q)))
    else $error("PWM match did not toggle");
  cmp_step_a: assert property (@(posedge clk) disable iff (!rst_n)
    (enabled && mode_cmp && edge_seen && !at_reload && !wr_en) |=>
      (count_q == $past(count_q) + 16'h0001))
    else $error("Comparator edge miscounted");
  cmp_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (mode_cmp && !edge_seen && !wr_en) |=> $stable(count_q))
    else $error("Count moved without an edge");
  // shared pin driven only in dual mode
  pin_select_a: assert property (@(posedge clk) disable iff (!rst_n)
    timer_in_select |=> !timer_out_comp_q)
    else $error("Complement driven while pin is an input");
  wrap_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    (tick && count_q == 16'hffff && !at_reload && !wr_en) |=> (count_q == 16'h0000))
    else $error("Count did not wrap");
  start_level_a: assert property (@(posedge clk) disable iff (!rst_n)
    (enabled && !enabled_prev_q) |-> (level_q == $past(polarity)))
    else $error("Start level does not follow polarity");
  dual_restore_a: assert property (@(posedge clk) disable iff (!rst_n)
    (enabled && mode_pwm2 && tick && at_reload) |=> (level_q == $past(polarity)))
    else $error("Dual PWM level not restored at reload");
endmodule : tpwm_timer

// [tpwm_defines.svh]
// Register offsets, field positions, reset values and timing counts of the timer slice
`ifndef TPWM_DEFINES_SVH
`define TPWM_DEFINES_SVH
// ==========================================================
// Register byte offsets
`define TPWM_OFF_CTL0 12'h000
`define TPWM_OFF_CTL1 12'h004
`define TPWM_OFF_COUNT 12'h008
`define TPWM_OFF_RELOAD 12'h00c
`define TPWM_OFF_MATCH 12'h010
`define TPWM_OFF_DEAD 12'h014
// ==========================================================
// Field positions
`define TPWM_CTL0_EXTRA_BIT 0
`define TPWM_CTL0_OUTEN_BIT 1
`define TPWM_CTL1_ENABLE_BIT 7
`define TPWM_CTL1_POL_BIT 6
`define TPWM_CTL1_PRE_LSB 3
`define TPWM_CTL1_MODE_LSB 0
// ==========================================================
// Reset and reload values
`define TPWM_RELOAD_START 16'h0001
`define TPWM_COUNT_RESET 16'h0001
`define TPWM_RELOAD_RESET 16'hffff
`define TPWM_MATCH_RESET 16'h0000
`define TPWM_DEAD_RESET 8'h00
`define TPWM_DEAD_MAX 8'h80
`define TPWM_SYNC_STAGES 2
`endif

// [tpwm_pkg.sv]
// Types shared by the timer slice
package tpwm_pkg;
  // Mode code: {extra bit, 3-bit mode field}
  typedef enum logic [3:0] {
    TPWM_MODE_CMPCNT = 4'h5,
    TPWM_MODE_PWM1 = 4'h3,
    TPWM_MODE_PWM2 = 4'h8
  } tpwm_mode_type;
  // Deadband sequencer states
  typedef enum logic [2:0] {
    TPWM_DB_IDLE = 3'b001,
    TPWM_DB_WAIT = 3'b010,
    TPWM_DB_RUN = 3'b100
  } tpwm_db_type;
endpackage : tpwm_pkg

// [tpwm_deadband.sv]
// Deadband delay for one complementary output pair
`timescale 1ns/10ps
`include "tpwm_defines.svh"
module tpwm_deadband
  import tpwm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic active,
  input wire logic [7:0] dead_cycles,
  input wire logic level,
  // Outputs
  output logic out_p_q,
  output logic out_n_q
);
  tpwm_db_type state_q;
  logic [7:0] cnt_q;
  logic level_q;

  // ==========================================================
  // Sequencer
  // restart on transition
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= TPWM_DB_IDLE;
      cnt_q <= 8'h00;
      level_q <= 1'b0;
    end
    else if (!active)
    begin
      state_q <= TPWM_DB_IDLE;
      cnt_q <= 8'h00;
      level_q <= level;
    end
    else
    begin
      level_q <= level;
      case (state_q)
        TPWM_DB_IDLE:
        begin
          state_q <= TPWM_DB_RUN;
          cnt_q <= dead_cycles;
        end
        TPWM_DB_WAIT, TPWM_DB_RUN:
        begin
          if (level != level_q)
          begin
            state_q <= TPWM_DB_WAIT;
            cnt_q <= dead_cycles;
          end
          else if (cnt_q != 8'h00)
            cnt_q <= cnt_q - 8'h01;
          else
            state_q <= TPWM_DB_RUN;
        end
        default:
          state_q <= TPWM_DB_IDLE;
      endcase
    end
  end

  // delayed rising edges
  // The falling output drops at once; the rising one waits for the count to run out
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_p_q <= 1'b0;
      out_n_q <= 1'b0;
    end
    else if (!active)
    begin
      out_p_q <= 1'b0;
      out_n_q <= 1'b0;
    end
    else if (level != level_q || cnt_q != 8'h00 || state_q != TPWM_DB_RUN)
    begin
      out_p_q <= out_p_q & level;
      out_n_q <= out_n_q & ~level;
    end
    else
    begin
      out_p_q <= level;
      out_n_q <= ~level;
    end
  end

  pair_gap_a: assert property (@(posedge clk) disable iff (!rst_n)
    !(out_p_q && out_n_q)) else $error("Complementary outputs high together");
endmodule : tpwm_deadband

// [tpwm_cmp_src.sv]
// Comparator source model that drives clean pulses into the timer
`timescale 1ns/10ps
module tpwm_cmp_src
(
  // Clock
  input wire logic clk,
  // Comparator level
  output logic level
);
  initial level = 1'b0;
  // two-clock phases
  // Phases of two clocks sit exactly at the shortest pulse the timer must catch
  task automatic pulses(input int k);
    repeat (k)
    begin
      repeat (2) @(posedge clk);
      level <= 1'b1;
      repeat (2) @(posedge clk);
      level <= 1'b0;
    end
    repeat (5) @(posedge clk);
  endtask : pulses
endmodule : tpwm_cmp_src

// [tb.sv]
// Self-checking testbench for the timer slice
`timescale 1ns/10ps
`include "tpwm_defines.svh"
module tb
  import tpwm_pkg::*;
;
  logic clk, rst_n, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic pready, pslverr, err_q, cmp, t_out, t_comp, in_sel, ev_q;
  int fail_count = 0;
  int check_count = 0;
  int ev = 0;
  int e0, n, h, l, g, d;
  // ==========================================================
  // Design and comparator model
  tpwm_timer uut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .comparator_out(cmp),
    .timer_out_q(t_out), .timer_out_comp_q(t_comp),
    .timer_in_select(in_sel), .reload_event_q(ev_q));
  tpwm_cmp_src m (.clk(clk), .level(cmp));
  // Clock at 10 MHz
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Count reload events
  always @(posedge clk)
    if (ev_q === 1'b1) ev++;
  // ==========================================================
  // Tasks
  task chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      fail_count++;
      $display("CHECK FAILED %0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  // One APB transfer, held until pready is seen high
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task cfg(input logic [3:0] md, input logic pol, input logic [2:0] pre,
    input logic [15:0] st, input logic [15:0] rl, input logic [15:0] mt,
    input logic [7:0] db);
    xfer(1, `TPWM_OFF_CTL1, {24'h0, 1'b0, pol, pre, md[2:0]});
    xfer(1, `TPWM_OFF_CTL0, {30'h0, 1'b1, md[3]});
    xfer(1, `TPWM_OFF_COUNT, {16'h0, st});
    xfer(1, `TPWM_OFF_RELOAD, {16'h0, rl});
    xfer(1, `TPWM_OFF_MATCH, {16'h0, mt});
    xfer(1, `TPWM_OFF_DEAD, {24'h0, db});
    xfer(1, `TPWM_OFF_CTL1, {24'h0, 1'b1, pol, pre, md[2:0]});
  endtask : cfg
  // Wait for a level on the primary or complement output
  task waitv(input bit c, input logic v, output int k);
    k = 0;
    while ((c ? t_comp : t_out) !== v && k < 4000)
    begin
      @(negedge clk);
      k++;
    end
  endtask : waitv
  task complete_run;
    if (fail_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  // Watchdog well beyond the longest expected run
  initial
  begin
    #5000000;
    fail_count++;
    complete_run;
  end
  // ==========================================================
  // Main sequence
  initial
  begin
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    chk(in_sel, 1);
    xfer(0, `TPWM_OFF_COUNT, 0);
    chk(rd_q, 1);
    xfer(0, `TPWM_OFF_RELOAD, 0);
    chk(rd_q, 32'hffff);
    xfer(0, 12'h018, 0);
    chk({err_q, rd_q}, {1'b1, 32'h0});
    xfer(1, `TPWM_OFF_DEAD, 32'hff);
    xfer(0, `TPWM_OFF_DEAD, 0);
    chk(rd_q, 32'h80);
    // Comparator mode, rising edges, largest prescale ignored
    cfg(4'h5, 1, 3'h7, 16'h3, 16'h4, 0, 0);
    chk(t_out, 1);
    e0 = ev;
    m.pulses(1);
    xfer(0, `TPWM_OFF_COUNT, 0);
    chk(rd_q, 4);
    m.pulses(4);
    chk(32'(ev - e0), 1);
    xfer(0, `TPWM_OFF_COUNT, 0);
    chk(rd_q, 4);
    chk(t_out, 0);
    // Falling edges and wrap past all ones
    cfg(4'h5, 0, 3'h0, 16'hffff, 16'h2, 0, 0);
    chk(t_out, 0);
    m.pulses(1);
    xfer(0, `TPWM_OFF_COUNT, 0);
    chk(rd_q, 0);
    // Single PWM over both polarities and several prescales
    for (int i = 0; i < 4; i++)
    begin
      cfg(4'h3, ~i[0], (i < 2) ? 3'h0 : ((i == 2) ? 3'h1 : 3'h7), 1, 6, 2, 0);
      waitv(0, 0, n);
      waitv(0, 1, n);
      waitv(0, 0, h);
      waitv(0, 1, l);
      chk(32'(h + l), 32'(6 << ((i < 2) ? 0 : ((i == 2) ? 1 : 7))));
      chk(32'(h), 32'((i[0] ? 4 : 2) << ((i < 2) ? 0 : ((i == 2) ? 1 : 7))));
      chk(t_comp, 0);
    end
    // Dual PWM with deadbands of 0, 3 and 128
    for (int i = 0; i < 3; i++)
    begin
      d = (i == 0) ? 0 : ((i == 1) ? 3 : 128);
      cfg(4'h8, 1, 0, 1, 300, 150, d[7:0]);
      chk(in_sel, 0);
      // Skip the start-up drop while the deadband first settles
      waitv(0, 0, n);
      waitv(0, 1, n);
      waitv(0, 0, n);
      waitv(1, 1, g);
      chk(32'(g > d && g <= d + 2), 1);
      chk(t_out, 0);
      waitv(1, 0, n);
      waitv(0, 1, g);
      chk(32'(g > d && g <= d + 2), 1);
      chk(t_comp, 0);
    end
    complete_run;
  end
endmodule : tb
